// ---- common/period_timer_cfg.svh ----
`ifndef PERIOD_TIMER_CFG_SVH
`define PERIOD_TIMER_CFG_SVH

// Register byte addresses
`define ADDR_PERIOD_COUNT    8'h00
`define ADDR_PERIOD_VALUE    8'h04
`define ADDR_TIMER_CONTROL   8'h08
`define ADDR_IRQ_FLAG_REG    8'h0C
`define ADDR_IRQ_ENABLE_REG  8'h10

// Reset values
`define RST_PERIOD_COUNT     8'h00
`define RST_PERIOD_VALUE     8'hFF
`define RST_TIMER_CONTROL    8'h00

// Control field positions
`define CTL_PRESCALE_LSB     0
`define CTL_PRESCALE_MSB     1
`define CTL_TIMER_ON_BIT     2
`define CTL_POSTSCALE_LSB    3
`define CTL_POSTSCALE_MSB    6
`define CTL_WRITE_MASK       8'h7F

// Flag and enable bit position
`define IRQ_MATCH_BIT        0

// Timing: system clock per instruction clock, prescaler limits (ratio minus one)
`define INST_DIV_LAST        2'h3
`define PRE_LIMIT_1          6'h00
`define PRE_LIMIT_4          6'h03
`define PRE_LIMIT_16         6'h0F
`define PRE_LIMIT_64         6'h3F
`endif

// ---- common/period_timer_pkg.sv ----
package period_timer_pkg;
  typedef logic [31:0] word_t;
  typedef logic [7:0]  byte_t;
  typedef logic [1:0]  htrans_t;
  typedef logic [2:0]  hsize_t;
  typedef enum logic [1:0]
  {
    PRE_DIV_1  = 2'h0,
    PRE_DIV_4  = 2'h1,
    PRE_DIV_16 = 2'h2,
    PRE_DIV_64 = 2'h3
  } prescale_t;
  localparam htrans_t HTRANS_NONSEQ = 2'h2;
  localparam htrans_t HTRANS_SEQ    = 2'h3;
endpackage

// ---- hdl/period_timer_8bit.sv ----
// Chosen here: the AHB-Lite interface to the registers and the placing of the registers.
`include "period_timer_cfg.svh"

module period_timer_8bit
(
  input  wire logic                     clk,          // System clock
  input  wire logic                     reset,        // Sync reset, active high
  input  wire logic                     sleep,        // Processor in sleep
  input  wire logic                     hsel,         // AHB slave select
  input  wire logic [31:0]              haddr,        // AHB address
  input  wire period_timer_pkg::htrans_t htrans,      // AHB transfer type
  input  wire logic                     hwrite,       // AHB write
  input  wire period_timer_pkg::hsize_t hsize,        // AHB size
  input  wire period_timer_pkg::word_t  hwdata,       // AHB write data
  input  wire logic                     hready,       // AHB bus ready
  output logic                          hreadyout,    // AHB slave ready
  output logic                          hresp,        // AHB response
  output period_timer_pkg::word_t       hrdata,       // AHB read data
  output logic                          period_match, // Match to peripherals
  output logic                          irq           // Match interrupt request
);
  import period_timer_pkg::*;

  // ----------------------------------------
  // Bus address phase capture
  // ----------------------------------------
  logic       wr_pend_ff;
  logic       nxt_wr_pend;
  logic [7:0] wr_addr_ff;
  logic [7:0] nxt_wr_addr;
  word_t      rdata_ff;
  word_t      nxt_rdata;
  logic       addr_phase;

  byte_t      count_ff;
  byte_t      period_ff;
  byte_t      control_ff;
  logic       flag_ff;
  logic       enable_ff;

  assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  always_comb
  begin
    nxt_wr_pend = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    nxt_rdata   = rdata_ff;
    if (addr_phase)
    begin
      nxt_wr_pend = hwrite;
      nxt_wr_addr = haddr[7:0];
      if (!hwrite)
      begin
        nxt_rdata = 32'h0000_0000;
        if (haddr[31:8] == 24'h00_0000)
        begin
          case (haddr[7:0])
            `ADDR_PERIOD_COUNT:   nxt_rdata[7:0] = count_ff;
            `ADDR_PERIOD_VALUE:   nxt_rdata[7:0] = period_ff;
            `ADDR_TIMER_CONTROL:  nxt_rdata[7:0] = control_ff;
            `ADDR_IRQ_FLAG_REG:   nxt_rdata[`IRQ_MATCH_BIT] = flag_ff;
            `ADDR_IRQ_ENABLE_REG: nxt_rdata[`IRQ_MATCH_BIT] = enable_ff;
            default:              nxt_rdata = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff   <= nxt_rdata;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;

  // ----------------------------------------
  // Register write strobes
  // ----------------------------------------
  logic wr_count;
  logic wr_period;
  logic wr_control;
  logic wr_flag;
  logic wr_enable;

  assign wr_count   = wr_pend_ff && (wr_addr_ff == `ADDR_PERIOD_COUNT);
  assign wr_period  = wr_pend_ff && (wr_addr_ff == `ADDR_PERIOD_VALUE);
  assign wr_control = wr_pend_ff && (wr_addr_ff == `ADDR_TIMER_CONTROL);
  assign wr_flag    = wr_pend_ff && (wr_addr_ff == `ADDR_IRQ_FLAG_REG);
  assign wr_enable  = wr_pend_ff && (wr_addr_ff == `ADDR_IRQ_ENABLE_REG);

  // ----------------------------------------
  // Control and period registers
  // ----------------------------------------
  byte_t     nxt_period;
  byte_t     nxt_control;
  logic      nxt_enable;
  logic      timer_on;
  prescale_t prescale_sel;
  logic [3:0] postscale_sel;

  assign timer_on      = control_ff[`CTL_TIMER_ON_BIT];
  assign prescale_sel  = prescale_t'(control_ff[`CTL_PRESCALE_MSB:`CTL_PRESCALE_LSB]);
  assign postscale_sel = control_ff[`CTL_POSTSCALE_MSB:`CTL_POSTSCALE_LSB];

  always_comb
  begin
    nxt_period  = period_ff;
    nxt_control = control_ff;
    nxt_enable  = enable_ff;
    if (wr_period)
    begin
      nxt_period = hwdata[7:0];
    end
    if (wr_control)
    begin
      nxt_control = hwdata[7:0] & `CTL_WRITE_MASK;
    end
    if (wr_enable)
    begin
      nxt_enable = hwdata[`IRQ_MATCH_BIT];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      period_ff  <= `RST_PERIOD_VALUE;
      control_ff <= `RST_TIMER_CONTROL;
      enable_ff  <= 1'b0;
    end
    else
    begin
      period_ff  <= nxt_period;
      control_ff <= nxt_control;
      enable_ff  <= nxt_enable;
    end
  end

  // ----------------------------------------
  // Instruction clock and prescaler
  // ----------------------------------------
  logic [1:0] inst_div_ff;
  logic [1:0] nxt_inst_div;
  logic [5:0] pre_cnt_ff;
  logic [5:0] nxt_pre_cnt;
  logic [5:0] pre_limit;
  logic       inst_tick;
  logic       running;
  logic       timer_tick;
  logic       scaler_clear;

  assign inst_tick    = (inst_div_ff == `INST_DIV_LAST);
  assign running      = timer_on && !sleep;
  assign scaler_clear = wr_count || wr_control;

  always_comb
  begin
    case (prescale_sel)
      PRE_DIV_1:  pre_limit = `PRE_LIMIT_1;
      PRE_DIV_4:  pre_limit = `PRE_LIMIT_4;
      PRE_DIV_16: pre_limit = `PRE_LIMIT_16;
      PRE_DIV_64: pre_limit = `PRE_LIMIT_64;
      default:    pre_limit = `PRE_LIMIT_1;
    endcase
  end

  assign timer_tick = running && inst_tick && (pre_cnt_ff >= pre_limit) && !scaler_clear;

  always_comb
  begin
    nxt_inst_div = inst_div_ff + 2'h1;
    nxt_pre_cnt  = pre_cnt_ff;
    if (scaler_clear)
    begin
      nxt_pre_cnt = 6'h00;
    end
    else if (running && inst_tick)
    begin
      if (pre_cnt_ff >= pre_limit)
      begin
        nxt_pre_cnt = 6'h00;
      end
      else
      begin
        nxt_pre_cnt = pre_cnt_ff + 6'h01;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      inst_div_ff <= 2'h0;
      pre_cnt_ff  <= 6'h00;
    end
    else
    begin
      inst_div_ff <= nxt_inst_div;
      pre_cnt_ff  <= nxt_pre_cnt;
    end
  end

  // ----------------------------------------
  // Count register and comparator
  // ----------------------------------------
  byte_t nxt_count;
  logic  equal;
  logic  match_ff;
  logic  nxt_match;

  assign equal = (count_ff == period_ff);

  always_comb
  begin
    nxt_count = count_ff;
    if (wr_count)
    begin
      nxt_count = hwdata[7:0];
    end
    else if (timer_tick)
    begin
      if (equal)
      begin
        nxt_count = 8'h00;
      end
      else
      begin
        nxt_count = count_ff + 8'h01;
      end
    end
  end

  // Match follows the compare, so it lasts while count holds the period value
  assign nxt_match = (nxt_count == nxt_period);

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      count_ff <= `RST_PERIOD_COUNT;
      match_ff <= 1'b0;
    end
    else
    begin
      count_ff <= nxt_count;
      match_ff <= nxt_match;
    end
  end

  assign period_match = match_ff;

  // ----------------------------------------
  // Postscaler and interrupt flag
  // ----------------------------------------
  logic [3:0] post_cnt_ff;
  logic [3:0] nxt_post_cnt;
  logic       nxt_flag;
  logic       match_event;
  logic       post_done;
  logic       irq_ff;
  logic       nxt_irq;

  assign match_event = timer_tick && equal;
  assign post_done   = match_event && (post_cnt_ff == postscale_sel);

  always_comb
  begin
    nxt_post_cnt = post_cnt_ff;
    if (scaler_clear)
    begin
      nxt_post_cnt = 4'h0;
    end
    else if (post_done)
    begin
      nxt_post_cnt = 4'h0;
    end
    else if (match_event)
    begin
      nxt_post_cnt = post_cnt_ff + 4'h1;
    end
  end

  always_comb
  begin
    nxt_flag = flag_ff;
    if (wr_flag && hwdata[`IRQ_MATCH_BIT])
    begin
      nxt_flag = 1'b0;
    end
    // Set wins over a clear in the same cycle
    if (post_done)
    begin
      nxt_flag = 1'b1;
    end
    nxt_irq = nxt_flag && nxt_enable;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      post_cnt_ff <= 4'h0;
      flag_ff     <= 1'b0;
      irq_ff      <= 1'b0;
    end
    else
    begin
      post_cnt_ff <= nxt_post_cnt;
      flag_ff     <= nxt_flag;
      irq_ff      <= nxt_irq;
    end
  end

  assign irq = irq_ff;

endmodule

// ---- verif/period_timer_8bit_tb.sv ----
`include "period_timer_cfg.svh"

module period_timer_8bit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import period_timer_pkg::*;
  logic        clk;
  logic        reset;
  logic        sleep;
  logic        hsel;
  logic [31:0] haddr;
  htrans_t     htrans;
  logic        hwrite;
  hsize_t      hsize;
  word_t       hwdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  word_t       hrdata;
  logic        period_match;
  logic        irq;
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cycles = 0;

  period_timer_8bit u_dut
  (
    .clk, .reset, .sleep, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .period_match, .irq
  );
  assign hready = hreadyout;

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      error_cnt++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input string name, input word_t seen, input word_t exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // ----------------------------
  // Single AHB-Lite transfer
  // ----------------------------
  task automatic bus(input byte_t a, input logic w, input byte_t d, output word_t rd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic wr(input byte_t a, input byte_t d);
    word_t v;
    bus(a, 1'b1, d, v);
  endtask

  task automatic rd(input byte_t a, output word_t v);
    bus(a, 1'b0, 8'h00, v);
  endtask

  task automatic t_reset_map();
    word_t v;
    rd(`ADDR_PERIOD_COUNT, v);
    check("count reset", v, 32'h00);
    rd(`ADDR_PERIOD_VALUE, v);
    check("period reset", v, 32'hFF);
    rd(`ADDR_TIMER_CONTROL, v);
    check("control reset", v, 32'h00);
    rd(8'h20, v);
    check("unmapped read", v, 32'h00);
    wr(`ADDR_PERIOD_VALUE, 8'h5A);
    rd(`ADDR_PERIOD_VALUE, v);
    check("period rw", v, 32'h5A);
    wr(`ADDR_PERIOD_COUNT, 8'h33);
    wr(`ADDR_TIMER_CONTROL, 8'hF8);
    rd(`ADDR_TIMER_CONTROL, v);
    check("control rw", v, 32'h78);
    rd(`ADDR_PERIOD_COUNT, v);
    check("count kept", v, 32'h33);
  endtask

  task automatic t_prescale();
    int hi;
    int per;
    for (int ps = 0; ps < 4; ps++)
    begin
      wr(`ADDR_PERIOD_VALUE, 8'h03);
      wr(`ADDR_PERIOD_COUNT, 8'h00);
      wr(`ADDR_TIMER_CONTROL, {5'h00, 1'b1, 2'(ps)});
      while (period_match !== 1'b1) @(posedge clk);
      hi = 0;
      while (period_match === 1'b1)
      begin
        hi++;
        @(posedge clk);
      end
      per = hi;
      while (period_match !== 1'b1)
      begin
        per++;
        @(posedge clk);
      end
      check("match width", hi, 4 << (2 * ps));
      check("match period", per, 16 << (2 * ps));
    end
  endtask

  task automatic t_postscale();
    int   n;
    logic prev;
    int   codes [3] = '{0, 2, 15};
    word_t v;
    wr(`ADDR_IRQ_ENABLE_REG, 8'h01);
    wr(`ADDR_PERIOD_VALUE, 8'h01);
    foreach (codes[i])
    begin
      wr(`ADDR_TIMER_CONTROL, 8'h00);
      wr(`ADDR_IRQ_FLAG_REG, 8'h01);
      wr(`ADDR_PERIOD_COUNT, 8'h00);
      check("irq cleared", irq, 1'b0);
      wr(`ADDR_TIMER_CONTROL, {1'b0, 4'(codes[i]), 3'b100});
      n = 0;
      prev = period_match;
      while (irq !== 1'b1)
      begin
        @(posedge clk);
        if (period_match === 1'b1 && prev === 1'b0)
          n++;
        prev = period_match;
      end
      check("post ratio", n, codes[i] + 1);
    end
    wr(`ADDR_TIMER_CONTROL, 8'h00);
    repeat (20) @(posedge clk);
    check("flag sticky", irq, 1'b1);
    wr(`ADDR_IRQ_ENABLE_REG, 8'h00);
    repeat (2) @(posedge clk);
    check("irq masked", irq, 1'b0);
    rd(`ADDR_IRQ_FLAG_REG, v);
    check("flag read", v, 32'h01);
    rd(`ADDR_IRQ_ENABLE_REG, v);
    check("enable read", v, 32'h00);
    wr(`ADDR_IRQ_ENABLE_REG, 8'h01);
    repeat (2) @(posedge clk);
    check("irq unmasked", irq, 1'b1);
    wr(`ADDR_IRQ_FLAG_REG, 8'h01);
    repeat (2) @(posedge clk);
    check("flag cleared", irq, 1'b0);
  endtask

  task automatic t_post_clear();
    int   n;
    logic prev;
    wr(`ADDR_TIMER_CONTROL, 8'h00);
    wr(`ADDR_IRQ_FLAG_REG, 8'h01);
    wr(`ADDR_PERIOD_COUNT, 8'h00);
    wr(`ADDR_TIMER_CONTROL, 8'h14);
    n = 0;
    prev = period_match;
    while (n < 2)
    begin
      @(posedge clk);
      if (period_match === 1'b1 && prev === 1'b0)
        n++;
      prev = period_match;
    end
    wr(`ADDR_PERIOD_COUNT, 8'h00);
    n = 0;
    prev = period_match;
    while (irq !== 1'b1)
    begin
      @(posedge clk);
      if (period_match === 1'b1 && prev === 1'b0)
        n++;
      prev = period_match;
    end
    check("post cleared", n, 3);
  endtask

  task automatic t_hold();
    word_t a;
    word_t b;
    wr(`ADDR_PERIOD_VALUE, 8'hFF);
    wr(`ADDR_TIMER_CONTROL, 8'h04);
    repeat (40) @(posedge clk);
    sleep <= 1'b1;
    rd(`ADDR_PERIOD_COUNT, a);
    repeat (40) @(posedge clk);
    rd(`ADDR_PERIOD_COUNT, b);
    check("sleep count", b, a);
    rd(`ADDR_PERIOD_VALUE, b);
    check("sleep period", b, 32'hFF);
    sleep <= 1'b0;
    wr(`ADDR_TIMER_CONTROL, 8'h00);
    rd(`ADDR_PERIOD_COUNT, a);
    repeat (40) @(posedge clk);
    rd(`ADDR_PERIOD_COUNT, b);
    check("stopped count", b, a);
    wr(`ADDR_TIMER_CONTROL, 8'h04);
    repeat (40) @(posedge clk);
    rd(`ADDR_PERIOD_COUNT, b);
    check("count moves", 32'(b > a), 32'h1);
  endtask

  initial
  begin
    reset = 1'b1;
    sleep = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset_map();
    t_prescale();
    t_postscale();
    t_post_clear();
    t_hold();
    summarize();
  end
endmodule

// ---- verif/period_timer_checker_properties.sv ----
module period_timer_checker
(
  input wire logic                      clk,          // Clock
  input wire logic                      reset,        // Reset
  input wire logic                      sleep,        // Sleep
  input wire logic                      hsel,         // Select
  input wire logic [31:0]               haddr,        // Address
  input wire period_timer_pkg::htrans_t htrans,       // Transfer
  input wire logic                      hwrite,       // Write
  input wire logic                      hready,       // Ready in
  input wire logic                      hreadyout,    // Ready out
  input wire logic                      hresp,        // Response
  input wire period_timer_pkg::word_t   hrdata,       // Read data
  input wire logic                      period_match, // Match
  input wire logic                      irq           // Request
);
  timeunit 1ns;
  timeprecision 1ps;
  import period_timer_pkg::*;
  logic       rd_req;
  logic       wr_req;
  logic [3:0] wr_hist_ff;
  assign rd_req = hsel && hready && htrans[1] && !hwrite;
  assign wr_req = hsel && hready && htrans[1] && hwrite;
  always_ff @(posedge clk)
    wr_hist_ff <= reset ? 4'h0 : {wr_hist_ff[2:0], wr_req};
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_reset_clear: assert property ($fell(reset) |-> !irq && !period_match)
    else $error("outputs not clear after reset");
  a_match_width: assert property (
    (!hsel)[*2] ##1 $rose(period_match) |=> period_match[*2])
    else $error("match pulse too short");
  a_irq_sticky: assert property ($fell(irq) |-> |wr_hist_ff)
    else $error("irq fell without a write");
  a_sleep_hold: assert property (
    (sleep && !hsel)[*4] |-> $stable(period_match) && $stable(irq))
    else $error("activity during sleep");
  a_upper_zero: assert property (hrdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (rd_req && haddr > 32'h10 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_ctl_top_zero: assert property (rd_req && haddr == 32'h08 |=> !hrdata[7])
    else $error("control bit 7 set");
  a_rdata_hold: assert property (!rd_req |=> $stable(hrdata))
    else $error("read data moved without a read");
  a_irq_cause: assert property ($rose(irq) |-> $past(period_match) || wr_hist_ff[1])
    else $error("irq rose without match or write");
  c_irq_rise: cover property ($rose(irq));
  c_irq_fall: cover property ($fell(irq));
  c_sleep: cover property ((sleep && !hsel)[*4]);
endmodule

bind period_timer_8bit period_timer_checker u_chk
(
  .clk, .reset, .sleep, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .period_match, .irq
);
